// ### spc_baud.v
// half-bit tick generator for the master serial clock
`timescale 1ns/1ps
`include "spc_map.vh"
module spc_baud (
  input wire sys_clk,
  input wire rst_b,
  input wire run,
  input wire [2:0] prescale,
  input wire [3:0] rate_exp,
  output reg tick_q
);

  reg [11:0] cnt_q;
  wire [3:0] exp_c;
  wire [11:0] half_div;
  wire [11:0] limit;

  // reserved exponent codes are clamped to the largest divisor
  assign exp_c = (rate_exp > `SPC_RATE_EXP_MAX) ? `SPC_RATE_EXP_MAX : rate_exp;
  // half period = (prescale + 1) * 2^exp, the full bit is twice that
  assign half_div = ({9'h000, prescale} + 12'h001) << exp_c;
  assign limit = half_div - 12'h001;

  // counter restarts whenever the master is idle so the first edge is a full half bit away
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 12'h000;
      tick_q <= 1'b0;
    end else if (!run) begin
      cnt_q <= 12'h000;
      tick_q <= 1'b0;
    end else if (cnt_q == limit) begin
      cnt_q <= 12'h000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 12'h001;
      tick_q <= 1'b0;
    end
  end

endmodule

// ### spc_map.vh
// register offsets, field positions and reset values of the spi pin and control block
`ifndef SPC_MAP_VH
`define SPC_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SPC_OFS_CTRL1 4'h0
`define SPC_OFS_CTRL2 4'h1
`define SPC_OFS_RATE 4'h2
`define SPC_OFS_STATUS 4'h3
`define SPC_OFS_DATA_HI 4'h4
`define SPC_OFS_DATA_LO 4'h5
`define SPC_OFS_MATCH_HI 4'h6
`define SPC_OFS_MATCH_LO 4'h7
`define SPC_OFS_CTRL3 4'h8
`define SPC_OFS_IRQ_CLR 4'h9

// ----------------------------------------
// reset values and write masks
// ----------------------------------------
`define SPC_RST_CTRL1 8'h04
`define SPC_RST_CTRL2 8'h00
`define SPC_RST_RATE 8'h00
`define SPC_RST_CTRL3 8'h00
`define SPC_WMASK_CTRL2 8'hdb
`define SPC_WMASK_RATE 8'h7f

// ----------------------------------------
// control_one fields
// ----------------------------------------
`define SPC_C1_RX_IRQ 7
`define SPC_C1_ENABLE 6
`define SPC_C1_TX_IRQ 5
`define SPC_C1_MASTER 4
`define SPC_C1_POL 3
`define SPC_C1_PHASE 2
`define SPC_C1_SEL_OUT 1
`define SPC_C1_LOW_FIRST 0

// ----------------------------------------
// control_two, control_three and status fields
// ----------------------------------------
`define SPC_C2_MATCH_IRQ 7
`define SPC_C2_WIDE 6
`define SPC_C2_FAULT_EN 4
`define SPC_C2_BIDIR_OE 3
`define SPC_C2_PIN_MODE 0
`define SPC_C3_QUEUE 0
`define SPC_ST_RX_FULL 7
`define SPC_ST_MATCH 6
`define SPC_ST_TX_EMPTY 5
`define SPC_ST_FAULT 4

// ----------------------------------------
// shift timing
// ----------------------------------------
`define SPC_LAST_EDGE_8 5'd15
`define SPC_LAST_EDGE_16 5'd31
`define SPC_RATE_EXP_MAX 4'h8

`endif

// ### spc_slave_model.sv
// far-side spi slave used while the block runs as master
`timescale 1ns/1ps
module spc_slave_model (
  input wire sck,
  input wire ss_b,
  input wire mosi,
  input wire pol,
  input wire pha,
  input wire wide,
  input wire lsb,
  input wire [15:0] tx_word,
  output reg miso,
  output reg [15:0] rx_word
);
  integer n;
  // wire order of the k-th bit; the word itself keeps its msb on top
  function integer pos(input integer k);
    pos = lsb ? k : (wide ? 15 : 7) - k;
  endfunction
  initial begin
    miso = 1'b0;
    rx_word = 16'h0000;
    n = 0;
  end
  // selection opens a frame; phase 0 needs bit 0 out before any edge
  always @(negedge ss_b) begin
    n = 0;
    rx_word = 16'h0000;
    if (!pha) miso = tx_word[pos(0)];
  end
  // released line: never leave a value the master could trust
  always @(posedge ss_b) miso = ~miso;
  // leading edge is the one leaving the idle level
  always @(sck) begin
    if (!ss_b && n < (wide ? 16 : 8)) begin
      if ((sck != pol) != pha) begin
        rx_word[pos(n)] = mosi;
        n = n + 1;
      end else if (pha || n > 0) begin
        miso = tx_word[pos(n)];
      end
    end
  end
endmodule

// ### spc_top.v
// spi pin routing, control registers and shift engine
// Operation
// - enable low: all four pins go back to their other functions
// - serial clock pin is input as slave, driven output as master
// - normal pin mode: mosi is data out as master, data in as slave
// - single-wire master: mosi is the data pin, direction set by output enable
// - single-wire slave: mosi unused and released
// - normal pin mode: miso is data in as master, data out as slave
// - single-wire slave: miso is the data pin, direction set by output enable
// - single-wire master: miso unused and released
// - slave select is active low; the master pulls it low to select us
// - master select pin: released, fault input, or automatic select output
// - receive enable gates interrupt on receive full or mode fault
// - clearing enable disables, idles and resets all status flags
// - transmit enable requests interrupt while transmit empty is set
// - master select bit: 0 slave, 1 master
// - polarity 0 idles clock low, 1 idles it high; both ends must match
// - phase 0 first edge mid bit, phase 1 first edge at bit start
// - shift order bit picks lsb or msb first; register layout fixed
// - match enable requests interrupt while receive match flag is set
// - word length bit sizes shifter, match and buffers to 8 or 16 bits
// - master word length change aborts, idles and resets flags
// - receive full set at transfer end, cleared by status then data read
`timescale 1ns/1ps
`include "spc_map.vh"
module spc_top (
  input wire sys_clk,
  input wire rst_b,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire sck_in,
  output reg sck_out,
  output reg sck_oe,
  output reg sck_claim,
  input wire mosi_in,
  output reg mosi_out,
  output reg mosi_oe,
  output reg mosi_claim,
  input wire miso_in,
  output reg miso_out,
  output reg miso_oe,
  output reg miso_claim,
  input wire ss_b_in,
  output reg ss_b_out,
  output reg ss_b_oe,
  output reg ss_claim,
  output reg irq_req
);

  // ----------------------------------------
  // state and storage
  // ----------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  reg [7:0] ctrl1_q, ctrl2_q, rate_q, ctrl3_q, match_hi_q, match_lo_q;
  reg [7:0] tx_hi_q, tx_lo_q;
  reg [15:0] rx_buf_q, sh_tx_q, sh_rx_q;
  reg [4:0] edge_q;
  reg state_q, sck_lvl_q, dout_q, wide_prev_q, ss_idle_q;
  reg rx_full_q, match_q, tx_empty_q, fault_q;
  reg arm_rx_q, arm_tx_q, arm_match_q, arm_fault_q;
  reg [3:0] sync1_q, sync2_q;
  reg sck_prev_q;
  wire tick;

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  wire system_enable = ctrl1_q[`SPC_C1_ENABLE];
  wire master_select = ctrl1_q[`SPC_C1_MASTER];
  wire clock_polarity = ctrl1_q[`SPC_C1_POL];
  wire clock_phase = ctrl1_q[`SPC_C1_PHASE];
  wire select_output_enable = ctrl1_q[`SPC_C1_SEL_OUT];
  wire low_bit_first = ctrl1_q[`SPC_C1_LOW_FIRST];
  wire receive_irq_enable = ctrl1_q[`SPC_C1_RX_IRQ];
  wire transmit_irq_enable = ctrl1_q[`SPC_C1_TX_IRQ];
  wire match_irq_enable = ctrl2_q[`SPC_C2_MATCH_IRQ];
  wire wide = ctrl2_q[`SPC_C2_WIDE];
  wire mode_fault_enable = ctrl2_q[`SPC_C2_FAULT_EN];
  wire bidir_output_enable = ctrl2_q[`SPC_C2_BIDIR_OE];
  wire single_wire_pin_mode = ctrl2_q[`SPC_C2_PIN_MODE];
  wire queue_mode_enable = ctrl3_q[`SPC_C3_QUEUE];

  // synchronised pin levels, order {sck, ss, mosi, miso}
  wire sck_s = sync2_q[3];
  wire ss_b_s = sync2_q[2];
  wire mosi_s = sync2_q[1];
  wire miso_s = sync2_q[0];

  wire is_master = system_enable & master_select;
  wire is_slave = system_enable & ~master_select;
  wire selected = is_slave & ~ss_b_s;
  wire fault_ev = is_master & mode_fault_enable & ~select_output_enable & ~ss_b_s;
  wire wide_flip = is_master & (wide != wide_prev_q);
  wire flag_reset = ~system_enable | wide_flip;
  wire abort = flag_reset | fault_ev | (is_slave & ss_b_s);
  wire [4:0] last_edge = wide ? `SPC_LAST_EDGE_16 : `SPC_LAST_EDGE_8;
  wire [15:0] width_mask = wide ? 16'hffff : 16'h00ff;
  wire [15:0] tx_word = {tx_hi_q, tx_lo_q} & width_mask;
  wire [15:0] match_word = {match_hi_q, match_lo_q} & width_mask;

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  // register bit that carries serial bit idx; storage keeps msb at bit 7 or 15
  function [3:0] bit_pos;
    input [3:0] idx;
    input lsb_first;
    input wide_mode;
    begin
      if (lsb_first) begin
        bit_pos = idx;
      end else if (wide_mode) begin
        bit_pos = 4'd15 - idx;
      end else begin
        bit_pos = 4'd7 - idx;
      end
    end
  endfunction

  // data input follows the pin mode and role
  wire din = is_master ? (single_wire_pin_mode ? mosi_s : miso_s)
    : (single_wire_pin_mode ? miso_s : mosi_s);

  // master edges come from the divider, slave edges from the synchronised clock
  wire link_ev = is_master ? tick : (sck_s != sck_prev_q);
  wire ev = (state_q == ST_RUN) & link_ev;
  // sampling edge is the leading one for phase 0, the trailing one for phase 1
  wire sample_now = ev & (edge_q[0] == clock_phase);
  wire [3:0] bit_idx = edge_q[4:1];
  wire [3:0] drive_idx = clock_phase ? bit_idx : bit_idx + 4'd1;
  wire load_go = (state_q == ST_IDLE) & ~abort & ((is_master & ~tx_empty_q) | selected);
  wire done = ev & (edge_q == last_edge);

  reg [15:0] rx_cur;
  // receive shifter with the bit of this cycle merged in
  always @* begin
    rx_cur = sh_rx_q;
    if (sample_now) begin
      rx_cur[bit_pos(bit_idx, low_bit_first, wide)] = din;
    end
  end

  spc_baud u_baud (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .run(is_master & (state_q == ST_RUN)),
    .prescale(rate_q[6:4]),
    .rate_exp(rate_q[3:0]),
    .tick_q(tick)
  );

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // the first stage feeds only the second; the edge detector looks at stage two
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 4'hf;
      sync2_q <= 4'hf;
      sck_prev_q <= 1'b1; // matches the synchroniser reset, so no false edge
    end else begin
      sync1_q <= {sck_in, ss_b_in, mosi_in, miso_in};
      sync2_q <= sync1_q;
      sck_prev_q <= sync2_q[3];
    end
  end

  // ----------------------------------------
  // register writes and status flags
  // ----------------------------------------
  // all clears but the disable or width reset are written first so that a hardware set in the same cycle wins
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl1_q <= `SPC_RST_CTRL1;
      ctrl2_q <= `SPC_RST_CTRL2;
      rate_q <= `SPC_RST_RATE;
      ctrl3_q <= `SPC_RST_CTRL3;
      match_hi_q <= 8'h00;
      match_lo_q <= 8'h00;
      tx_hi_q <= 8'h00;
      tx_lo_q <= 8'h00;
      wide_prev_q <= 1'b0;
      rx_full_q <= 1'b0;
      match_q <= 1'b0;
      tx_empty_q <= 1'b1;
      fault_q <= 1'b0;
      arm_rx_q <= 1'b0;
      arm_tx_q <= 1'b0;
      arm_match_q <= 1'b0;
      arm_fault_q <= 1'b0;
    end else begin
      wide_prev_q <= wide;
      if (reg_wr) begin
        case (reg_addr)
          `SPC_OFS_CTRL1: ctrl1_q <= reg_wdata;
          `SPC_OFS_CTRL2: ctrl2_q <= reg_wdata & `SPC_WMASK_CTRL2;
          `SPC_OFS_RATE: rate_q <= reg_wdata & `SPC_WMASK_RATE;
          `SPC_OFS_CTRL3: ctrl3_q <= reg_wdata;
          `SPC_OFS_MATCH_HI: match_hi_q <= reg_wdata;
          `SPC_OFS_MATCH_LO: match_lo_q <= reg_wdata;
          `SPC_OFS_DATA_HI: tx_hi_q <= reg_wdata;
          `SPC_OFS_DATA_LO: tx_lo_q <= reg_wdata;
          default: ;
        endcase
      end
      // reading status arms the clear of each flag that is set
      if (reg_rd && reg_addr == `SPC_OFS_STATUS) begin
        arm_rx_q <= rx_full_q;
        arm_tx_q <= tx_empty_q;
        arm_match_q <= match_q;
        arm_fault_q <= fault_q;
      end
      if (reg_rd && reg_addr == `SPC_OFS_DATA_LO && arm_rx_q) begin
        rx_full_q <= 1'b0;
        arm_rx_q <= 1'b0;
      end
      // the low byte write commits the word, so a 16-bit write goes high then low
      if (reg_wr && reg_addr == `SPC_OFS_DATA_LO && arm_tx_q) begin
        tx_empty_q <= 1'b0;
        arm_tx_q <= 1'b0;
      end
      if (reg_wr && reg_addr == `SPC_OFS_STATUS && reg_wdata[`SPC_ST_MATCH] && arm_match_q) begin
        match_q <= 1'b0;
        arm_match_q <= 1'b0;
      end
      if (reg_wr && reg_addr == `SPC_OFS_CTRL1 && arm_fault_q) begin
        fault_q <= 1'b0;
        arm_fault_q <= 1'b0;
      end
      // hardware sets
      if (load_go) begin
        tx_empty_q <= 1'b1;
      end
      if (done && !abort) begin
        rx_full_q <= 1'b1;
        if ((rx_cur & width_mask) == match_word) begin
          match_q <= 1'b1;
        end
      end
      if (fault_ev) begin
        fault_q <= 1'b1;
      end
      // disable or a master width change returns every flag to its reset value
      if (flag_reset) begin
        rx_full_q <= 1'b0;
        match_q <= 1'b0;
        tx_empty_q <= 1'b1;
        fault_q <= 1'b0;
        arm_rx_q <= 1'b0;
        arm_tx_q <= 1'b0;
        arm_match_q <= 1'b0;
        arm_fault_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // shift engine
  // ----------------------------------------
  // one edge counter serves both roles; only the source of edges differs
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      edge_q <= 5'd0;
      sck_lvl_q <= 1'b0;
      dout_q <= 1'b0;
      sh_tx_q <= 16'h0000;
      sh_rx_q <= 16'h0000;
      rx_buf_q <= 16'h0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          edge_q <= 5'd0;
          sck_lvl_q <= 1'b0;
          if (load_go) begin
            state_q <= ST_RUN;
            sh_tx_q <= tx_word;
            sh_rx_q <= 16'h0000;
            dout_q <= tx_word[bit_pos(4'd0, low_bit_first, wide)];
          end
        end
        ST_RUN: begin
          if (abort) begin
            state_q <= ST_IDLE;
            edge_q <= 5'd0;
            sck_lvl_q <= 1'b0;
          end else if (ev) begin
            sck_lvl_q <= ~sck_lvl_q;
            edge_q <= edge_q + 5'd1;
            sh_rx_q <= rx_cur;
            if (!sample_now && !done) begin
              dout_q <= sh_tx_q[bit_pos(drive_idx, low_bit_first, wide)];
            end
            if (done) begin
              state_q <= ST_IDLE;
              rx_buf_q <= rx_cur & width_mask;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // pin routing
  // ----------------------------------------
  // registered so that every pin output leaves a flip-flop; costs one cycle of skew
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
      sck_claim <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      mosi_claim <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      miso_claim <= 1'b0;
      ss_b_out <= 1'b1;
      ss_idle_q <= 1'b1;
      ss_b_oe <= 1'b0;
      ss_claim <= 1'b0;
    end else begin
      // idle level follows polarity, toggles while a word runs in either role; the pin is driven only as master
      sck_out <= clock_polarity ^ sck_lvl_q;
      sck_oe <= is_master;
      sck_claim <= system_enable;
      mosi_out <= dout_q;
      mosi_oe <= is_master & (~single_wire_pin_mode | bidir_output_enable);
      mosi_claim <= system_enable & ~(single_wire_pin_mode & ~master_select);
      miso_out <= dout_q;
      // in normal pin mode the slave drives miso only while selected so several slaves can share it
      miso_oe <= is_slave & (single_wire_pin_mode ? bidir_output_enable : ~ss_b_s);
      miso_claim <= system_enable & ~(single_wire_pin_mode & master_select);
      ss_idle_q <= (state_q == ST_IDLE); // holds select past the last clock edge
      ss_b_out <= (state_q == ST_IDLE) & ss_idle_q;
      ss_b_oe <= is_master & mode_fault_enable & select_output_enable;
      ss_claim <= system_enable & (~master_select | mode_fault_enable);
    end
  end

  // ----------------------------------------
  // interrupt request and read port
  // ----------------------------------------
  // without a queue implemented, receive full also stands for queue full
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_req <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      irq_req <= system_enable & (
        (receive_irq_enable & (rx_full_q | (fault_q & ~queue_mode_enable))) |
        (transmit_irq_enable & tx_empty_q) |
        (match_irq_enable & match_q));
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `SPC_OFS_CTRL1: reg_rdata <= ctrl1_q;
          `SPC_OFS_CTRL2: reg_rdata <= ctrl2_q;
          `SPC_OFS_RATE: reg_rdata <= rate_q;
          `SPC_OFS_STATUS: reg_rdata <= {rx_full_q, match_q, tx_empty_q, fault_q, 4'h0};
          `SPC_OFS_DATA_HI: reg_rdata <= rx_buf_q[15:8];
          `SPC_OFS_DATA_LO: reg_rdata <= rx_buf_q[7:0];
          `SPC_OFS_MATCH_HI: reg_rdata <= match_hi_q;
          `SPC_OFS_MATCH_LO: reg_rdata <= match_lo_q;
          `SPC_OFS_CTRL3: reg_rdata <= ctrl3_q;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

// ### spc_top_properties.sv
// concurrent checks of pin ownership and read-back for spc_top
`timescale 1ns/1ps
module spc_top_properties (
  input wire sys_clk,
  input wire rst_b,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire sck_out,
  input wire sck_oe,
  input wire sck_claim,
  input wire mosi_oe,
  input wire mosi_claim,
  input wire miso_oe,
  input wire miso_claim,
  input wire ss_b_out,
  input wire ss_b_oe,
  input wire ss_claim
);
  reg [7:0] c1_q;
  reg [7:0] c2_q;
  // ----------------------------------------
  // shadow control registers
  // ----------------------------------------
  // same write edge as the block, so pins trail the shadow by one sample
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      c1_q <= 8'h04;
      c2_q <= 8'h00;
    end else if (reg_wr && reg_addr == 4'h0) begin
      c1_q <= reg_wdata;
    end else if (reg_wr && reg_addr == 4'h1) begin
      c2_q <= reg_wdata;
    end
  end
  wire en = c1_q[6];
  wire mst = c1_q[4];
  wire pm = c2_q[0];
  wire boe = c2_q[3];
  wire fen = c2_q[4];
  wire soe = c1_q[1];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_DISABLED_RELEASE: assert property (
    !$past(en) |-> !sck_claim && !sck_oe && !mosi_claim && !miso_claim && !ss_claim)
    else $error("pins held while disabled");
  AST_SCK_DIR: assert property (
    $past(en) |-> sck_claim && sck_oe == $past(mst)) else $error("clock pin direction");
  AST_MOSI_NORMAL: assert property (
    $past(en && !pm) |-> mosi_claim && mosi_oe == $past(mst)) else $error("mosi normal");
  AST_MOSI_SINGLE: assert property (
    $past(en && pm && mst) |-> mosi_claim && mosi_oe == $past(boe))
    else $error("mosi single wire");
  AST_MOSI_UNUSED: assert property (
    $past(en && pm && !mst) |-> !mosi_claim && !mosi_oe) else $error("mosi not released");
  AST_MISO_NORMAL: assert property (
    $past(en && !pm) |-> miso_claim && !(miso_oe && $past(mst))) else $error("miso normal");
  AST_MISO_SINGLE: assert property (
    $past(en && pm && !mst) |-> miso_claim && (!miso_oe || $past(boe)))
    else $error("miso single wire");
  AST_MISO_UNUSED: assert property (
    $past(en && pm && mst) |-> !miso_claim && !miso_oe) else $error("miso not released");
  AST_SS_SLAVE: assert property (
    $past(en && !mst) |-> ss_claim && !ss_b_oe) else $error("select not an input");
  AST_SS_MASTER: assert property (
    $past(en && mst) |-> ss_claim == $past(fen) && ss_b_oe == $past(fen && soe))
    else $error("master select pin use");
  AST_SS_AUTO: assert property (
    $past(en && mst && fen && soe) && $past(c1_q) == $past(c1_q, 3) && $changed(sck_out)
    |-> !ss_b_out) else $error("clock moved with select high");
  AST_READ_IDLE: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside its cycle");
  AST_CTRL_READBACK: assert property (
    $past(reg_rd && reg_addr == 4'h0) |-> reg_rdata == $past(c1_q))
    else $error("control one read back");
  // main scenarios reached
  cover property ($fell(ss_b_out));
  cover property ($past(en && pm && mst) && mosi_oe);
  cover property ($past(en && mst && fen) && ss_claim && !ss_b_oe);
endmodule

// ### tb_spc_top.sv
// self-checking bench of the spi pin and control block
`timescale 1ns/1ps
module tb_spc_top;
  reg sys_clk = 1'b0;
  reg rst_b = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg tb_sck = 1'b0;
  reg tb_mosi = 1'b0;
  reg tb_ss_b = 1'b1;
  reg [3:0] m_cfg = 4'h0;
  reg [15:0] slv_tx = 16'h0000;
  wire [7:0] reg_rdata;
  wire sck_out, sck_oe, sck_claim, mosi_out, mosi_oe, mosi_claim;
  wire miso_out, miso_oe, miso_claim, ss_b_out, ss_b_oe, ss_claim, irq_req, m_miso;
  wire [15:0] m_rx;
  integer err_total = 0;
  integer checked = 0;
  integer i, n;
  reg [31:0] r;
  reg [7:0] c1, c2, d, hi;
  reg [15:0] tx, rx_exp, mt, got;
  localparam [87:0] RST_TAB = 88'h00_00_00_00_00_00_00_20_00_00_04;
  // pin levels: whoever enables its driver owns the wire
  wire sck_w = sck_oe ? sck_out : tb_sck;
  wire mosi_w = mosi_oe ? mosi_out : tb_mosi;
  wire miso_w = miso_oe ? miso_out : m_miso;
  wire ss_w = ss_b_oe ? ss_b_out : tb_ss_b;
  spc_top u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .sck_claim(sck_claim),
    .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .mosi_claim(mosi_claim),
    .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .miso_claim(miso_claim),
    .ss_b_in(ss_w), .ss_b_out(ss_b_out), .ss_b_oe(ss_b_oe), .ss_claim(ss_claim),
    .irq_req(irq_req));
  spc_slave_model u_far (.sck(sck_w), .ss_b(ss_w), .mosi(mosi_w), .pol(m_cfg[3]),
    .pha(m_cfg[2]), .wide(m_cfg[1]), .lsb(m_cfg[0]), .tx_word(slv_tx), .miso(m_miso),
    .rx_word(m_rx));
  initial forever #2.5 sys_clk = ~sys_clk;
  // ----------------------------------------
  // bus tasks and expectations
  // ----------------------------------------
  task chk(input [15:0] e, input [15:0] g, input [8*20:1] what);
    begin
      checked = checked + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0s expected %h seen %h", what, e, g);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] v);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, output [7:0] v);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
    end
  endtask
  task tick(input integer k);
    begin
      repeat (k) @(posedge sys_clk);
      #1;
    end
  endtask
  // arm the transmitter and wait, bounded, for receive full
  task xfer(input [15:0] t);
    begin
      rd(4'h3, d);
      wr(4'h4, t[15:8]);
      wr(4'h5, t[7:0]);
      n = 0;
      d = 8'h00;
      while (d[7] !== 1'b1 && n < 400) begin
        rd(4'h3, d);
        n = n + 1;
      end
      chk(16'h0001, {15'h0, d[7]}, "receive full");
    end
  endtask
  task finish_test;
    begin
      $display("mismatches %0d comparisons %0d", err_total, checked);
      if (err_total == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  function [15:0] wmask(input [15:0] v, input w);
    wmask = w ? v : {8'h00, v[7:0]};
  endfunction
  // expected {sck claim, sck oe, mosi claim, miso claim, ss claim, ss oe}
  function [5:0] pins(input [7:0] a, input [7:0] b);
    pins = a[6] ? {1'b1, a[4], !(b[0] && !a[4]), !(b[0] && a[4]), !a[4] || b[4],
      a[4] && b[4] && a[1]} : 6'h00;
  endfunction
  initial begin
    #100000;
    err_total = err_total + 1;
    finish_test;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    r = $urandom(32'h6ee2aaae);
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (i = 0; i < 11; i = i + 1) begin
      rd(i[3:0], d);
      chk({8'h00, RST_TAB[i*8 +: 8]}, {8'h00, d}, "reset value");
    end
    // random pin configurations; the select line stays high so no fault
    for (i = 0; i < 16; i = i + 1) begin
      r = $urandom;
      c1 = r[7:0];
      c2 = r[15:8] & 8'h59;
      wr(4'h0, c1);
      wr(4'h1, c2);
      tick(2);
      chk({10'h0, pins(c1, c2)}, {10'h0, sck_claim, sck_oe, mosi_claim, miso_claim,
        ss_claim, ss_b_oe}, "pin routing");
      rd(4'h0, d);
      chk({8'h00, c1}, {8'h00, d}, "control one");
    end
    // eight master words in random formats, against the far-side model
    for (i = 0; i < 8; i = i + 1) begin
      r = $urandom;
      m_cfg = r[3:0];
      tx = r[31:16];
      r = $urandom;
      slv_tx = r[15:0];
      rx_exp = wmask(r[15:0], m_cfg[1]);
      mt = i[0] ? rx_exp : ~rx_exp;
      wr(4'h0, 8'h00);
      wr(4'h1, {1'b1, m_cfg[1], 6'h10});
      wr(4'h2, 8'h02);
      wr(4'h6, mt[15:8]);
      wr(4'h7, mt[7:0]);
      wr(4'h0, {4'h5, m_cfg[3:2], 1'b1, m_cfg[0]});
      xfer(tx);
      chk(wmask(tx, m_cfg[1]), m_rx, "far side word");
      chk({15'h0, i[0]}, {15'h0, d[6]}, "match flag");
      chk({15'h0, i[0]}, {15'h0, irq_req}, "match request");
      rd(4'h4, hi);
      rd(4'h5, d);
      chk(rx_exp, wmask({hi, d}, m_cfg[1]), "received word");
      rd(4'h3, d);
      chk(16'h0000, {15'h0, d[7]}, "full cleared");
      wr(4'h3, 8'h40);
      tick(2);
      chk(16'h0000, {15'h0, irq_req}, "match cleared");
    end
    // width change in mid-word
    wr(4'h2, 8'h07);
    wr(4'h1, 8'h10);
    wr(4'h0, 8'h52);
    rd(4'h3, d);
    wr(4'h5, 8'ha5);
    tick(20);
    chk(16'h0000, {15'h0, ss_b_out}, "select during word");
    wr(4'h1, 8'h50);
    tick(3);
    chk(16'h0001, {15'h0, ss_b_out}, "select after abort");
    rd(4'h3, d);
    chk(16'h0020, {8'h00, d}, "status after abort");
    // receive full left standing, then the module is switched off
    wr(4'h2, 8'h02);
    wr(4'h1, 8'h10);
    xfer(16'h003c);
    wr(4'h0, 8'h12);
    rd(4'h3, d);
    chk(16'h0020, {8'h00, d}, "status when off");
    wr(4'h0, 8'h60);
    tick(3);
    chk(16'h0001, {15'h0, irq_req}, "transmit request");
    wr(4'h0, 8'h40);
    tick(3);
    chk(16'h0000, {15'h0, irq_req}, "transmit masked");
    // select pulled low under a master with fault detection
    wr(4'h0, 8'hd0);
    @(posedge sys_clk) tb_ss_b <= 1'b0;
    tick(6);
    chk(16'h0001, {15'h0, irq_req}, "fault request");
    rd(4'h3, d);
    chk(16'h0001, {15'h0, d[4]}, "fault flag");
    wr(4'h8, 8'h01);
    tick(3);
    chk(16'h0000, {15'h0, irq_req}, "queue masks fault");
    wr(4'h8, 8'h00);
    @(posedge sys_clk) tb_ss_b <= 1'b1;
    // slave word clocked by the bench at 48 ns, phase 0, msb first
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h40);
    rd(4'h3, d);
    wr(4'h5, 8'h96);
    tb_ss_b <= 1'b0;
    got = 16'h0000;
    #100;
    hi = 8'h69;
    for (i = 7; i >= 0; i = i - 1) begin
      tb_mosi <= hi[i];
      #24 tb_sck <= 1'b1;
      got[i] = miso_w;
      #24 tb_sck <= 1'b0;
    end
    #60 tb_ss_b <= 1'b1;
    tb_mosi <= ~tb_mosi;
    chk(16'h0096, got, "slave out");
    tick(4);
    rd(4'h5, d);
    chk(16'h0069, {8'h00, d}, "slave in");
    finish_test;
  end
endmodule
bind spc_top spc_top_properties u_props (.sys_clk(sys_clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .sck_out(sck_out), .sck_oe(sck_oe), .sck_claim(sck_claim),
  .mosi_oe(mosi_oe), .mosi_claim(mosi_claim), .miso_oe(miso_oe), .miso_claim(miso_claim),
  .ss_b_out(ss_b_out), .ss_b_oe(ss_b_oe), .ss_claim(ss_claim));
